// File: inc/got_pkg.sv
// Purpose: Shared constants and types of the ground overcurrent timer
// Assumes: 16-bit register port, millisecond timing base
// Notes: Curve equations live upstream; only base delays in ms enter here
package got_pkg;
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int ACC_W = 32;
  // Register byte offsets
  localparam logic [AW-1:0] REG_CTRL = 6'h00;
  localparam logic [AW-1:0] REG_PICKUP = 6'h04;
  localparam logic [AW-1:0] REG_DEF_DLY = 6'h08;
  localparam logic [AW-1:0] REG_TCHAR = 6'h0C;
  localparam logic [AW-1:0] REG_RST_HOLD = 6'h10;
  localparam logic [AW-1:0] REG_HARM = 6'h14;
  localparam logic [AW-1:0] REG_NOMINAL = 6'h18;
  localparam logic [AW-1:0] REG_GLOBAL = 6'h1C;
  localparam logic [AW-1:0] REG_STATUS = 6'h20;
  localparam logic [AW-1:0] REG_EVENT = 6'h24;
  localparam logic [AW-1:0] REG_ACCUM = 6'h28;
  // Reset values
  localparam logic [DW-1:0] CTRL_RST = 16'h0000;
  localparam logic [DW-1:0] PICKUP_RST = 16'h0064;
  localparam logic [DW-1:0] DEF_DLY_RST = 16'h0064;
  localparam logic [DW-1:0] TCHAR_RST = 16'h0064;
  localparam logic [DW-1:0] RST_HOLD_RST = 16'h0000;
  localparam logic [DW-1:0] HARM_RST = 16'h000F;
  localparam logic [DW-1:0] NOMINAL_RST = 16'h0064;
  localparam logic [1:0] GLOBAL_RST = 2'h0;
  localparam int GBL_CUR_BIT = 0;
  localparam int GBL_VOLT_BIT = 1;
  // Scaling: multiplier in hundredths, ratio in percent, nominal limits in tenths
  localparam int TCHAR_DIV = 100;
  localparam int RATIO_SCALE = 100;
  localparam int LIM_PICKUP_X = 20;
  localparam int LIM_DER_X10 = 400;
  localparam int LIM_SEN_X10 = 250;
  localparam int LIM_SNS_X10 = 25;
  localparam int LIM_DIV = 10;
  // Timing
  localparam int CLK_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYC = MS_NS / CLK_NS;
  localparam real LOG_MINIMUM_DELAY_S = 0.02;
  localparam int LOG_MINIMUM_DELAY_MS = int'(LOG_MINIMUM_DELAY_S * 1000.0);
  typedef enum logic [1:0] {MODE_NONDIR, MODE_FWD, MODE_REV} got_mode_t;
  typedef enum logic [1:0] {SRC_DERIVED, SRC_SENSED, SRC_SENSITIVE} got_src_t;
  typedef enum logic [1:0] {RST_INST, RST_DEF, RST_INV} got_rst_t;
  typedef enum logic [3:0] {
    CRV_DEFINITE, CRV_IEC_NORMAL, CRV_IEC_VERY, CRV_IEC_LONG,
    CRV_IEC_EXTREME, CRV_ANSI_MODERATE, CRV_ANSI_VERY, CRV_ANSI_EXTREME,
    CRV_R_INVERSE, CRV_LOGARITHMIC, CRV_THERM_FLAT, CRV_THERM_IT,
    CRV_THERM_I2T, CRV_THERM_I4T
  } got_curve_t;
  typedef struct packed {
    logic [2:0] spare;
    logic inrush_en;
    logic three_phase;
    got_src_t src;
    logic rms;
    got_rst_t rst_mode;
    got_curve_t curve;
    got_mode_t mode;
  } got_ctrl_t;
  typedef struct packed {
    logic [DW-1:0] fund;
    logic [DW-1:0] rms;
  } got_meas_t;
  typedef struct packed {
    logic fwd;
    logic rev;
  } got_dir_t;
  typedef struct packed {
    logic [DW-1:0] h1;
    logic [DW-1:0] h2;
  } got_harm_t;
  typedef struct packed {
    logic [8:0] spare;
    logic evt;
    logic all_blk;
    logic [2:0] blk;
    logic trip;
    logic pickup;
  } got_status_t;
endpackage

// File: hdl/got_ratio_cmp.sv
// Purpose: Second to first harmonic ratio test for one phase
// Assumes: Magnitudes from upstream on core_clk
// Notes: Products are 32 bits so no ratio setting can overflow
`timescale 1ns/1ps
`default_nettype none
module got_ratio_cmp (
  // Phase harmonics
  input wire got_pkg::got_harm_t harm,
  // Settings
  input wire logic [got_pkg::DW-1:0] ratio_pct,
  input wire logic enable,
  // Result
  output logic over
);
  logic [31:0] lhs;
  logic [31:0] rhs;
  // Cross-multiplied to avoid a divider
  assign lhs = 32'(harm.h2) * 32'(got_pkg::RATIO_SCALE);
  assign rhs = 32'(harm.h1) * 32'(ratio_pct);
  assign over = enable && (lhs > rhs);
endmodule
`default_nettype wire

// File: hdl/got_tick.sv
// Purpose: Millisecond tick from the core clock
// Assumes: CYC of at least two
// Notes: Tick is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module got_tick #(
  parameter int CYC = got_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Tick
  output logic tick
);
  logic [31:0] cnt_q;
  // Free running divider
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == 32'(CYC - 1));
      if (cnt_q == 32'(CYC - 1)) begin
        cnt_q <= 32'h0;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: hdl/got_top.sv
// Purpose: Ground overcurrent trip timer with inrush blocking
// Assumes: Curve evaluator upstream returns base delays in ms
// Notes: Accumulated time counts in milliseconds
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Block when harmonic ratio exceeds threshold
// - Per-phase mode gives one block per phase
// - Three-phase mode gives one common block
// - Blocking logs a stage blocked event
// - Non-directional ignores all direction data
// - Mode non-directional, forward or reverse
// - Global direction sources apply to all
// - Derived source uses derived current, control
// - Sensed source uses sensed current, control
// - Sensitive input, sensed polarizing control
// - Fundamental or true RMS per setting
// - Fourteen selectable curves
// - Timing starts above pickup threshold
// - Definite curve resets with zero delay
// - Logarithmic: instantaneous or definite reset only
// - Other curves add inverse-time reset
// - Instantaneous reset clears timing within two cycles
// - Definite reset holds then clears
// - Non-definite delays scaled by time multiplier
// - Non-thermal delay never below minimum delay
// - Current limit is smaller of pickup bound and source nominal bound
// - Minimum delay at limit; logarithmic fixed 20 ms
// - Definite curve uses fixed delay setting
module got_top #(
  parameter int TICK_CYC = got_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [got_pkg::AW-1:0] reg_addr,
  input wire logic [got_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [got_pkg::DW-1:0] reg_rdata,
  // Residual current magnitudes
  input wire got_pkg::got_meas_t derived_residual_current,
  input wire got_pkg::got_meas_t sensed_residual_current,
  input wire got_pkg::got_meas_t sensitive_residual_current,
  // Direction results per polarizing control
  input wire got_pkg::got_dir_t derived_dir,
  input wire got_pkg::got_dir_t sensed_dir,
  // Phase harmonics, index 0 is phase a
  input wire got_pkg::got_harm_t [2:0] phase_harm,
  // Curve evaluator
  input wire logic [got_pkg::DW-1:0] curve_trip_ms,
  input wire logic [got_pkg::DW-1:0] curve_reset_ms,
  output logic [got_pkg::DW-1:0] eval_current,
  // Direction unit setup
  output logic direction_current_calc,
  output logic direction_voltage_source,
  output logic polarizing_sensed,
  // Element outputs
  output logic pickup,
  output logic trip,
  output logic phase_a_inrush_blocked,
  output logic phase_b_inrush_blocked,
  output logic phase_c_inrush_blocked,
  output logic all_phase_inrush_blocked,
  output logic block_event
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} got_st_t;

  logic rst_meta_q;
  logic rst_n_q;
  logic tick;
  got_pkg::got_ctrl_t ctrl_q;
  logic [got_pkg::DW-1:0] pickup_q;
  logic [got_pkg::DW-1:0] def_dly_q;
  logic [got_pkg::DW-1:0] tchar_q;
  logic [got_pkg::DW-1:0] hold_q;
  logic [got_pkg::DW-1:0] harm_q;
  logic [got_pkg::DW-1:0] nominal_q;
  logic [1:0] global_q;
  logic evt_q;
  logic [got_pkg::DW-1:0] rdata_q;
  logic [2:0] ph_over;
  logic [2:0] blk_ph_q;
  logic blk_all_q;
  logic blk_any;
  logic blk_prev_q;
  logic blk_evt_q;
  logic [got_pkg::DW-1:0] op_cur;
  got_pkg::got_dir_t dir_sel;
  logic dir_ok;
  logic over;
  logic definite_time_curve;
  logic logc;
  logic thermal;
  logic [31:0] lim_pick;
  logic [31:0] lim_nom;
  logic [31:0] cur_lim;
  logic [got_pkg::DW-1:0] eval_q;
  logic [31:0] trip_scaled;
  logic [31:0] reset_scaled;
  logic [got_pkg::ACC_W-1:0] eff_delay;
  logic [got_pkg::ACC_W-1:0] hold_lim;
  got_st_t st_q;
  got_st_t st_d;
  logic [got_pkg::ACC_W-1:0] acc_q;
  logic [got_pkg::ACC_W-1:0] hold_cnt_q;
  logic pickup_q2;
  logic trip_q;
  logic [2:0] dir_out_q;
  got_pkg::got_status_t status;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  got_tick #(
    .CYC(TICK_CYC)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n_q),
    .tick(tick)
  );

  // Settings registers
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= got_pkg::got_ctrl_t'(got_pkg::CTRL_RST);
      pickup_q <= got_pkg::PICKUP_RST;
      def_dly_q <= got_pkg::DEF_DLY_RST;
      tchar_q <= got_pkg::TCHAR_RST;
      hold_q <= got_pkg::RST_HOLD_RST;
      harm_q <= got_pkg::HARM_RST;
      nominal_q <= got_pkg::NOMINAL_RST;
      global_q <= got_pkg::GLOBAL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        got_pkg::REG_CTRL: ctrl_q <= got_pkg::got_ctrl_t'(reg_wdata);
        got_pkg::REG_PICKUP: pickup_q <= reg_wdata;
        got_pkg::REG_DEF_DLY: def_dly_q <= reg_wdata;
        got_pkg::REG_TCHAR: tchar_q <= reg_wdata;
        got_pkg::REG_RST_HOLD: hold_q <= reg_wdata;
        got_pkg::REG_HARM: harm_q <= reg_wdata;
        got_pkg::REG_NOMINAL: nominal_q <= reg_wdata;
        got_pkg::REG_GLOBAL: global_q <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // Sticky blocked event; a new event beats a same-cycle clear
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      evt_q <= 1'b0;
    end else if (blk_any && !blk_prev_q) begin
      evt_q <= 1'b1;
    end else if (reg_wr && reg_addr == got_pkg::REG_EVENT && reg_wdata[0]) begin
      evt_q <= 1'b0;
    end
  end

  assign status = '{spare: '0, evt: evt_q, all_blk: blk_all_q,
                    blk: blk_ph_q, trip: trip_q, pickup: pickup_q2};

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else if (!reg_rd) begin
      rdata_q <= '0;
    end else begin
      case (reg_addr)
        got_pkg::REG_CTRL: rdata_q <= ctrl_q;
        got_pkg::REG_PICKUP: rdata_q <= pickup_q;
        got_pkg::REG_DEF_DLY: rdata_q <= def_dly_q;
        got_pkg::REG_TCHAR: rdata_q <= tchar_q;
        got_pkg::REG_RST_HOLD: rdata_q <= hold_q;
        got_pkg::REG_HARM: rdata_q <= harm_q;
        got_pkg::REG_NOMINAL: rdata_q <= nominal_q;
        got_pkg::REG_GLOBAL: rdata_q <= {14'h0, global_q};
        got_pkg::REG_STATUS: rdata_q <= status;
        got_pkg::REG_EVENT: rdata_q <= {15'h0, evt_q};
        got_pkg::REG_ACCUM: rdata_q <= acc_q[got_pkg::DW-1:0];
        default: rdata_q <= '0;
      endcase
    end
  end

  // One ratio test per phase
  for (genvar p = 0; p < 3; p++) begin : g_ph
    got_ratio_cmp u_cmp (
      .harm(phase_harm[p]),
      .ratio_pct(harm_q),
      .enable(ctrl_q.inrush_en),
      .over(ph_over[p])
    );
  end

  // Blocking outputs by mode
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      blk_ph_q <= 3'h0;
      blk_all_q <= 1'b0;
      blk_prev_q <= 1'b0;
      blk_evt_q <= 1'b0;
    end else begin
      blk_ph_q <= ctrl_q.three_phase ? 3'h0 : ph_over;
      blk_all_q <= ctrl_q.three_phase && (|ph_over);
      blk_prev_q <= blk_any;
      blk_evt_q <= blk_any && !blk_prev_q;
    end
  end
  // Any phase block holds off the residual element
  assign blk_any = blk_all_q || (|blk_ph_q);

  // Operating quantity and direction by source
  always_comb begin
    case (ctrl_q.src)
      got_pkg::SRC_DERIVED: begin
        op_cur = ctrl_q.rms ? derived_residual_current.rms
                            : derived_residual_current.fund;
        dir_sel = derived_dir;
      end
      got_pkg::SRC_SENSED: begin
        op_cur = ctrl_q.rms ? sensed_residual_current.rms
                            : sensed_residual_current.fund;
        dir_sel = sensed_dir;
      end
      default: begin
        op_cur = ctrl_q.rms ? sensitive_residual_current.rms
                            : sensitive_residual_current.fund;
        dir_sel = sensed_dir;
      end
    endcase
  end

  // Direction test per element mode
  always_comb begin
    case (ctrl_q.mode)
      got_pkg::MODE_FWD: dir_ok = dir_sel.fwd;
      got_pkg::MODE_REV: dir_ok = dir_sel.rev;
      default: dir_ok = 1'b1;
    endcase
  end
  assign over = (op_cur > pickup_q) && dir_ok;

  // Curve class
  assign definite_time_curve = ctrl_q.curve == got_pkg::CRV_DEFINITE;
  assign logc = ctrl_q.curve == got_pkg::CRV_LOGARITHMIC;
  assign thermal = ctrl_q.curve >= got_pkg::CRV_THERM_FLAT;

  // Current limit: smallest of pickup bound and source nominal bound
  assign lim_pick = 32'(pickup_q) * 32'(got_pkg::LIM_PICKUP_X);
  always_comb begin
    case (ctrl_q.src)
      got_pkg::SRC_DERIVED:
        lim_nom = 32'(nominal_q) * 32'(got_pkg::LIM_DER_X10);
      got_pkg::SRC_SENSED:
        lim_nom = 32'(nominal_q) * 32'(got_pkg::LIM_SEN_X10);
      default:
        lim_nom = 32'(nominal_q) * 32'(got_pkg::LIM_SNS_X10);
    endcase
  end
  assign cur_lim = (lim_pick < lim_nom / 32'(got_pkg::LIM_DIV)) ?
                   lim_pick : lim_nom / 32'(got_pkg::LIM_DIV);

  // Curve is evaluated at the clamped current, so its delay at the
  // limit becomes the floor; thermal curves see the true current
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      eval_q <= '0;
    end else if (thermal || 32'(op_cur) <= cur_lim) begin
      eval_q <= op_cur;
    end else begin
      eval_q <= cur_lim[got_pkg::DW-1:0];
    end
  end

  // Multiplier scaling of the base curve delays
  assign trip_scaled = 32'(curve_trip_ms) * 32'(tchar_q)
                       / 32'(got_pkg::TCHAR_DIV);
  assign reset_scaled = 32'(curve_reset_ms) * 32'(tchar_q)
                        / 32'(got_pkg::TCHAR_DIV);

  // Effective trip delay
  always_comb begin
    if (definite_time_curve) begin
      eff_delay = 32'(def_dly_q);
    end else if (logc && trip_scaled < 32'(got_pkg::LOG_MINIMUM_DELAY_MS)) begin
      eff_delay = 32'(got_pkg::LOG_MINIMUM_DELAY_MS);
    end else begin
      eff_delay = trip_scaled;
    end
  end

  // Reset hold length; inverse reset is refused for logarithmic
  assign hold_lim = (ctrl_q.rst_mode == got_pkg::RST_INV && !logc) ?
                    reset_scaled : 32'(hold_q);

  // Timer state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (over) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!over) begin
          if (definite_time_curve || ctrl_q.rst_mode == got_pkg::RST_INST) begin
            st_d = ST_IDLE;
          end else begin
            st_d = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (over) begin
          st_d = ST_RUN;
        end else if (hold_cnt_q >= hold_lim) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Accumulated trip time, saturating
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q <= '0;
    end else if (st_d == ST_IDLE) begin
      acc_q <= '0;
    end else if (over && tick && acc_q != '1) begin
      acc_q <= acc_q + 32'h1;
    end
  end

  // Reset hold counter
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_cnt_q <= '0;
    end else if (st_q != ST_HOLD || over) begin
      hold_cnt_q <= '0;
    end else if (tick && hold_cnt_q != '1) begin
      hold_cnt_q <= hold_cnt_q + 32'h1;
    end
  end

  // Element outputs
  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pickup_q2 <= 1'b0;
      trip_q <= 1'b0;
      dir_out_q <= 3'h0;
    end else begin
      pickup_q2 <= over;
      trip_q <= over && st_q == ST_RUN && acc_q >= eff_delay
                && !blk_any;
      dir_out_q <= {ctrl_q.src != got_pkg::SRC_DERIVED,
                    global_q[got_pkg::GBL_VOLT_BIT],
                    global_q[got_pkg::GBL_CUR_BIT]};
    end
  end

  assign reg_rdata = rdata_q;
  assign eval_current = eval_q;
  assign direction_current_calc = dir_out_q[0];
  assign direction_voltage_source = dir_out_q[1];
  assign polarizing_sensed = dir_out_q[2];
  assign pickup = pickup_q2;
  assign trip = trip_q;
  assign phase_a_inrush_blocked = blk_ph_q[0];
  assign phase_b_inrush_blocked = blk_ph_q[1];
  assign phase_c_inrush_blocked = blk_ph_q[2];
  assign all_phase_inrush_blocked = blk_all_q;
  assign block_event = blk_evt_q;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_q);

  AST_PICKUP_FOLLOWS: assert property (
    over |=> pickup) else $error("pickup not shown");
  AST_TRIP_BLOCKED: assert property (
    blk_any |=> !trip) else $error("trip while blocked");
  AST_DEF_ZERO_RESET: assert property (
    st_q == ST_RUN && !over && definite_time_curve |=> acc_q == '0)
    else $error("definite curve kept timing");
  AST_INST_RESET: assert property (
    st_q != ST_IDLE && !over && ctrl_q.rst_mode == got_pkg::RST_INST
    && !$past(over) |=> acc_q == '0) else $error("instant reset late");
  AST_PHASE_BLOCK: assert property (
    !ctrl_q.three_phase && ph_over[1] |=> phase_b_inrush_blocked
    && !all_phase_inrush_blocked) else $error("phase block missing");
  AST_COMMON_BLOCK: assert property (
    ctrl_q.three_phase && (|ph_over) |=> all_phase_inrush_blocked
    && blk_ph_q == 3'h0) else $error("common block wrong");
  AST_BLOCK_EVENT: assert property (
    $rose(blk_any) |=> block_event && evt_q)
    else $error("block event not logged");
  AST_NONDIR: assert property (
    ctrl_q.mode == got_pkg::MODE_NONDIR && op_cur > pickup_q
    |=> pickup) else $error("direction used when nondirectional");
  AST_LOG_MIN: assert property (
    trip && $past(logc) |-> $past(acc_q) >= 32'(got_pkg::LOG_MINIMUM_DELAY_MS))
    else $error("log trip below floor");
  AST_CLAMP: assert property (
    !thermal |=> 32'(eval_current) <= $past(cur_lim))
    else $error("current not clamped");
  AST_DEF_DELAY: assert property (
    trip && $past(definite_time_curve) |-> $past(acc_q) >= 32'($past(def_dly_q)))
    else $error("definite trip early");

  COV_TRIP: cover property ($rose(trip));
  COV_BLOCK: cover property ($rose(block_event));
  COV_HOLD_CLEAR: cover property (st_q == ST_HOLD ##1 st_q == ST_IDLE);
endmodule
`default_nettype wire

// File: verification/got_top_bench.sv
// Purpose: Self-checking bench for the ground overcurrent trip timer
// Assumes: TICK_CYC of 4, so one millisecond lasts four clocks
// Notes: Curve delays are driven as plain levels, no evaluator model
`timescale 1ns/1ps
`default_nettype none
module got_top_bench;
  localparam int TC = 4;
  logic core_clk, nrst, reg_wr, reg_rd, pickup, trip, evt;
  logic blk_a, blk_b, blk_c, blk_all, dir_calc, volt_src, pol;
  logic [got_pkg::AW-1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, eval_cur, trip_ms, rst_ms, v;
  got_pkg::got_meas_t cur_der, cur_sen, cur_sns;
  got_pkg::got_dir_t dir_der, dir_sen;
  got_pkg::got_harm_t [2:0] harm;
  int failures, cmp_count, n, evt_seen;
  // Reset table; the last address is unmapped and reads zero
  logic [5:0] ra [8] = '{got_pkg::REG_CTRL, got_pkg::REG_PICKUP,
    got_pkg::REG_DEF_DLY, got_pkg::REG_TCHAR, got_pkg::REG_RST_HOLD,
    got_pkg::REG_HARM, got_pkg::REG_NOMINAL, 6'h3C};
  logic [15:0] rv [8] = '{got_pkg::CTRL_RST, got_pkg::PICKUP_RST,
    got_pkg::DEF_DLY_RST, got_pkg::TCHAR_RST, got_pkg::RST_HOLD_RST,
    got_pkg::HARM_RST, got_pkg::NOMINAL_RST, 16'h0000};
  // Control word, derived direction and expected pickup per row
  logic [15:0] pc [12] = '{16'h0001, 16'h0001, 16'h0001, 16'h0002,
    16'h0002, 16'h0000, 16'h0000, 16'h0200, 16'h0300, 16'h0400, 16'h0100,
    16'h0301};
  logic [1:0] pd [12] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0,
    2'h0, 2'h0, 2'h0, 2'h2};
  logic [11:0] pe = 12'h36A;
  // Source, nominal and expected clamped current per row
  logic [15:0] lc [6] = '{16'h0000, 16'h0200, 16'h0400, 16'h0000,
    16'h0200, 16'h0028};
  logic [15:0] ln [6] = '{16'h0064, 16'h0064, 16'h0064, 16'h000A,
    16'h000A, 16'h0064};
  logic [15:0] le [6] = '{16'h07D0, 16'h07D0, 16'h00FA, 16'h0190,
    16'h00FA, 16'hFFFF};

  got_top #(.TICK_CYC(TC)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .derived_residual_current(cur_der),
    .sensed_residual_current(cur_sen),
    .sensitive_residual_current(cur_sns), .derived_dir(dir_der),
    .sensed_dir(dir_sen), .phase_harm(harm), .curve_trip_ms(trip_ms),
    .curve_reset_ms(rst_ms), .eval_current(eval_cur),
    .direction_current_calc(dir_calc),
    .direction_voltage_source(volt_src), .polarizing_sensed(pol),
    .pickup(pickup), .trip(trip), .phase_a_inrush_blocked(blk_a),
    .phase_b_inrush_blocked(blk_b), .phase_c_inrush_blocked(blk_c),
    .all_phase_inrush_blocked(blk_all), .block_event(evt)
  );

  // Compare one value and count it
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write strobe for one cycle, taken at the second edge
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe is taken
  task automatic rd(logic [5:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  // Let an input change reach the registered outputs
  task automatic settle();
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // Overcurrent until trip, then drop it and look at the timer
  task automatic run_trip(int ms, logic held);
    @(posedge core_clk);
    cur_der.fund <= 16'h00C8;
    settle();
    chk("pickup", pickup, 1'b1);
    for (n = 1; n < 200 && trip !== 1'b1; n++) begin
      @(negedge core_clk);
    end
    chk("trip time", n >= (ms - 1) * TC && n <= ms * TC + 3, 1'b1);
    @(posedge core_clk);
    cur_der.fund <= 16'h0000;
    settle();
    chk("pickup drop", pickup, 1'b0);
    chk("trip drop", trip, 1'b0);
    rd(got_pkg::REG_ACCUM);
    chk("accum held", v != 16'h0000, held);
  endtask
  // Verdict and end of run, shared with the watchdog
  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Watchdog: the sequence needs about six hundred clocks
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
  // Block event is a one-cycle pulse, so count it where it stands
  always @(negedge core_clk) begin
    evt_seen += int'(evt === 1'b1);
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cur_der = '0;
    cur_sen = '0;
    cur_sns = '0;
    dir_der = '0;
    dir_sen = '0;
    harm = '0;
    trip_ms = 16'h000A;
    rst_ms = 16'h0004;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", v, rv[i]);
    end
    // Definite curve, then inverse at multiplier 0.50 of 10 ms
    wr(got_pkg::REG_DEF_DLY, 16'h0005);
    run_trip(5, 1'b0);
    wr(got_pkg::REG_CTRL, 16'h0004);
    wr(got_pkg::REG_TCHAR, 16'h0032);
    run_trip(5, 1'b0);
    // Definite-time reset keeps the timer for 3 ms
    wr(got_pkg::REG_CTRL, 16'h0044);
    wr(got_pkg::REG_RST_HOLD, 16'h0003);
    run_trip(5, 1'b1);
    repeat (24) @(posedge core_clk);
    rd(got_pkg::REG_ACCUM);
    chk("accum cleared", v, 16'h0000);
    // Inverse-time reset holds for the scaled reset delay of 20 ms
    wr(got_pkg::REG_CTRL, 16'h0084);
    rst_ms <= 16'h0028;
    run_trip(5, 1'b1);
    repeat (24) @(posedge core_clk);
    rd(got_pkg::REG_ACCUM);
    chk("accum inverse hold", v != 16'h0000, 1'b1);
    repeat (80) @(posedge core_clk);
    rd(got_pkg::REG_ACCUM);
    chk("accum cleared", v, 16'h0000);
    // Logarithmic: 2 ms from the curve is floored; inverse reset is refused, so the 3 ms definite hold applies
    wr(got_pkg::REG_CTRL, 16'h00A4);
    trip_ms <= 16'h0002;
    wr(got_pkg::REG_TCHAR, 16'h0064);
    run_trip(20, 1'b1);
    // Mode, source and measuring method against pickup
    @(posedge core_clk);
    cur_der.fund <= 16'h00C8;
    cur_sen.rms <= 16'h00C8;
    cur_sns.fund <= 16'h00C8;
    foreach (pc[i]) begin
      wr(got_pkg::REG_CTRL, pc[i]);
      dir_der <= pd[i];
      settle();
      chk("pickup", pickup, pe[i]);
      chk("polarizing", pol, pc[i][10:9] != 2'b00);
    end
    wr(got_pkg::REG_GLOBAL, 16'h0002);
    settle();
    chk("global sources", {dir_calc, volt_src}, 2'b01);
    // Current limit per source and nominal; thermal is not clamped
    @(posedge core_clk);
    cur_der.fund <= 16'hFFFF;
    cur_sen.fund <= 16'hFFFF;
    cur_sns.fund <= 16'hFFFF;
    foreach (lc[i]) begin
      wr(got_pkg::REG_CTRL, lc[i]);
      wr(got_pkg::REG_NOMINAL, ln[i]);
      repeat (2) settle();
      chk("eval current", eval_cur, le[i]);
    end
    // Inrush: phase b above 15 percent, phase c exactly on it
    // Trip delay raised to 30 ms while inrush blocking is in use
    wr(got_pkg::REG_DEF_DLY, 16'h001E);
    wr(got_pkg::REG_CTRL, 16'h1000);
    cur_der.fund <= 16'h00C8;
    harm[0] <= {16'h0064, 16'h000A};
    harm[1] <= {16'h0064, 16'h0014};
    harm[2] <= {16'h0064, 16'h000F};
    repeat (40) settle();
    chk("blocks", {blk_all, blk_c, blk_b, blk_a}, 4'h2);
    chk("trip blocked", trip, 1'b0);
    chk("event pulses", evt_seen, 16'h0001);
    rd(got_pkg::REG_EVENT);
    chk("event sticky", v, 16'h0001);
    wr(got_pkg::REG_CTRL, 16'h1800);
    repeat (2) settle();
    chk("blocks", {blk_all, blk_c, blk_b, blk_a}, 4'h8);
    @(posedge core_clk);
    harm <= '0;
    repeat (40) settle();
    chk("trip released", trip, 1'b1);
    wr(got_pkg::REG_EVENT, 16'h0001);
    rd(got_pkg::REG_EVENT);
    chk("event cleared", v, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
